// ### nsf_pkg.sv
// Package for the nested stack frame builder.
// Assumes a 32-bit flat stack address space with doubleword pushes.
package nsf_pkg;
  localparam int NSF_DW = 32;
  localparam int NSF_LVL_W = 5;
  localparam logic [NSF_DW-1:0] NSF_SLOT_BYTES = 32'h0000_0004;
  localparam logic [NSF_DW-1:0] NSF_PTR_RESET = 32'h0000_0000;
  localparam logic [NSF_LVL_W-1:0] NSF_LVL_ZERO = 5'h00;
  localparam logic [NSF_LVL_W-1:0] NSF_LVL_ONE = 5'h01;
  localparam int NSF_LVL_MAX = 31;
  // Segment select codes for the data access path.
  localparam logic NSF_SEG_DATA = 1'b0;
  localparam logic NSF_SEG_STACK = 1'b1;

  typedef enum logic [2:0] {
    NSF_IDLE,
    NSF_SAVE,
    NSF_RD,
    NSF_RDW,
    NSF_CPY,
    NSF_LINK,
    NSF_DONE
  } nsf_state_type;
endpackage

// ### nsf_mem_port.sv
// Registered request stage toward the stack memory data path.
// Assumes the memory returns rdata with a valid pulse, and accepts on ack.
`timescale 1ns/1ps
module nsf_mem_port
  import nsf_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Request from sequencer
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [NSF_DW-1:0] addr_i,
  input wire logic [NSF_DW-1:0] wdata_i,
  // Request toward memory
  output logic req_o,
  output logic we_o,
  output logic [NSF_DW-1:0] addr_o,
  output logic [NSF_DW-1:0] wdata_o,
  input wire logic ack_i
);
  logic req_r, req_nxt, we_r, we_nxt;
  logic [NSF_DW-1:0] addr_r, addr_nxt, wdata_r, wdata_nxt;

  always_comb begin
    req_nxt = req_r;
    we_nxt = we_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    if (req_r && ack_i) begin
      req_nxt = 1'b0;
    end
    if (req_i && !req_r) begin
      req_nxt = 1'b1;
      we_nxt = we_i;
      addr_nxt = addr_i;
      wdata_nxt = wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= NSF_PTR_RESET;
      wdata_r <= NSF_PTR_RESET;
    end else begin
      req_r <= req_nxt;
      we_r <= we_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  assign req_o = req_r;
  assign we_o = we_r;
  assign addr_o = addr_r;
  assign wdata_o = wdata_r;
endmodule

// ### nsf_builder.sv
// Sequencer for the procedure-entry frame builder.
// Assumes a single-clock memory path: a request holds until mem_ack_i,
// and read data arrive with mem_rvalid_i some cycles after the read ack.
//
// Operation
// - Takes storage count and depth zero to 31.
// - Depth zero: push base, copy top, reserve.
// - Depth-1 times: base minus four, push word.
// - Push captured frame address as last entry.
// - Base pointer loaded with captured frame address.
// - Top pointer lowered by storage count last.
// - Depth one copies nothing, pushes two words.
// - First display word is caller's base pointer.
// - Copy count depends only on new depth.
// - Base-pointer addressing defaults to stack segment.
// - Depth never affects privilege checks.
`timescale 1ns/1ps
module nsf_builder
  import nsf_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Instruction start and operands
  input wire logic start_i,
  input wire logic [NSF_DW-1:0] storage_i,
  input wire logic [7:0] level_i,
  input wire logic [NSF_DW-1:0] fbp_in_i,
  input wire logic [NSF_DW-1:0] stp_in_i,
  // Base register selection of other data accesses
  input wire logic base_is_fbp_i,
  // Results
  output logic busy_o,
  output logic done_o,
  output logic [NSF_DW-1:0] frame_base_pointer_o,
  output logic [NSF_DW-1:0] stack_top_pointer_o,
  output logic seg_sel_o,
  // Stack memory path
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [NSF_DW-1:0] mem_addr_o,
  output logic [NSF_DW-1:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [NSF_DW-1:0] mem_rdata_i,
  input wire logic mem_rvalid_i
);
  // ------------------------------------------------------------------
  // Sequencer state
  // ------------------------------------------------------------------
  nsf_state_type st_r, st_nxt;
  logic [NSF_DW-1:0] fbp_r, fbp_nxt, stp_r, stp_nxt;
  logic [NSF_DW-1:0] frame_r, frame_nxt, store_r, store_nxt, data_r, data_nxt;
  logic [NSF_LVL_W-1:0] lvl_r, lvl_nxt, cnt_r, cnt_nxt;
  logic done_r, done_nxt, seg_r, seg_nxt;
  logic req, we;
  logic [NSF_DW-1:0] addr, wdata;
  logic pend_r, pend_nxt;

  // Push helper: the new top is four below the old one.
  function automatic logic [NSF_DW-1:0] push_addr(input logic [NSF_DW-1:0] p);
    push_addr = p - NSF_SLOT_BYTES;
  endfunction

  always_comb begin
    st_nxt = st_r;
    fbp_nxt = fbp_r;
    stp_nxt = stp_r;
    frame_nxt = frame_r;
    store_nxt = store_r;
    data_nxt = data_r;
    lvl_nxt = lvl_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    pend_nxt = pend_r;
    req = 1'b0;
    we = 1'b1;
    addr = push_addr(stp_r);
    wdata = fbp_r;
    // Base-pointer based accesses go to the stack segment.
    seg_nxt = base_is_fbp_i ? NSF_SEG_STACK : NSF_SEG_DATA;
    unique case (st_r)
      NSF_IDLE: begin
        if (start_i) begin
          fbp_nxt = fbp_in_i;
          stp_nxt = stp_in_i;
          store_nxt = storage_i;
          lvl_nxt = level_i[NSF_LVL_W-1:0];
          st_nxt = NSF_SAVE;
        end
      end
      NSF_SAVE: begin
        req = !pend_r;
        wdata = fbp_r;
        pend_nxt = 1'b1;
        if (pend_r && mem_ack_i) begin
          pend_nxt = 1'b0;
          stp_nxt = push_addr(stp_r);
          frame_nxt = push_addr(stp_r);
          cnt_nxt = (lvl_r == NSF_LVL_ZERO) ? NSF_LVL_ZERO : lvl_r - NSF_LVL_ONE;
          if (lvl_r == NSF_LVL_ZERO) begin
            st_nxt = NSF_DONE;
          end else if (lvl_r == NSF_LVL_ONE) begin
            st_nxt = NSF_LINK;
          end else begin
            st_nxt = NSF_RD;
          end
        end
      end
      NSF_RD: begin
        req = !pend_r;
        we = 1'b0;
        addr = fbp_r - NSF_SLOT_BYTES;
        pend_nxt = 1'b1;
        if (pend_r && mem_ack_i) begin
          pend_nxt = 1'b0;
          fbp_nxt = fbp_r - NSF_SLOT_BYTES;
          st_nxt = NSF_RDW;
        end
      end
      NSF_RDW: begin
        if (mem_rvalid_i) begin
          data_nxt = mem_rdata_i;
          st_nxt = NSF_CPY;
        end
      end
      NSF_CPY: begin
        req = !pend_r;
        wdata = data_r;
        pend_nxt = 1'b1;
        if (pend_r && mem_ack_i) begin
          pend_nxt = 1'b0;
          stp_nxt = push_addr(stp_r);
          cnt_nxt = cnt_r - NSF_LVL_ONE;
          st_nxt = (cnt_r == NSF_LVL_ONE) ? NSF_LINK : NSF_RD;
        end
      end
      NSF_LINK: begin
        req = !pend_r;
        wdata = frame_r;
        pend_nxt = 1'b1;
        if (pend_r && mem_ack_i) begin
          pend_nxt = 1'b0;
          stp_nxt = push_addr(stp_r);
          st_nxt = NSF_DONE;
        end
      end
      NSF_DONE: begin
        fbp_nxt = frame_r;
        stp_nxt = stp_r - store_r;
        done_nxt = 1'b1;
        st_nxt = NSF_IDLE;
      end
      default: begin
        st_nxt = NSF_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= NSF_IDLE;
      fbp_r <= NSF_PTR_RESET;
      stp_r <= NSF_PTR_RESET;
      frame_r <= NSF_PTR_RESET;
      store_r <= NSF_PTR_RESET;
      data_r <= NSF_PTR_RESET;
      lvl_r <= NSF_LVL_ZERO;
      cnt_r <= NSF_LVL_ZERO;
      done_r <= 1'b0;
      seg_r <= NSF_SEG_DATA;
      pend_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      fbp_r <= fbp_nxt;
      stp_r <= stp_nxt;
      frame_r <= frame_nxt;
      store_r <= store_nxt;
      data_r <= data_nxt;
      lvl_r <= lvl_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      seg_r <= seg_nxt;
      pend_r <= pend_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Memory request stage
  // ------------------------------------------------------------------
  nsf_mem_port u_port (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .req_i(req),
    .we_i(we),
    .addr_i(addr),
    .wdata_i(wdata),
    .req_o(mem_req_o),
    .we_o(mem_we_o),
    .addr_o(mem_addr_o),
    .wdata_o(mem_wdata_o),
    .ack_i(mem_ack_i)
  );

  logic busy_r;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (st_nxt != NSF_IDLE);
    end
  end

  assign busy_o = busy_r;
  assign done_o = done_r;
  assign frame_base_pointer_o = fbp_r;
  assign stack_top_pointer_o = stp_r;
  assign seg_sel_o = seg_r;

  // ------------------------------------------------------------------
  // Check helpers
  // ------------------------------------------------------------------
  // Copies pushed so far in this entry, so the display length can be checked.
  logic [NSF_LVL_W-1:0] chk_copies_r, chk_copies_nxt;

  always_comb begin
    chk_copies_nxt = chk_copies_r;
    if (st_r == NSF_IDLE) begin
      chk_copies_nxt = NSF_LVL_ZERO;
    end else if (st_r == NSF_CPY && mem_req_o && mem_ack_i) begin
      chk_copies_nxt = chk_copies_r + NSF_LVL_ONE;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chk_copies_r <= NSF_LVL_ZERO;
    end else begin
      chk_copies_r <= chk_copies_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_link_push;
    mem_req_o && mem_we_o && mem_ack_i && (st_r == NSF_LINK);
  endsequence

  property p_link_data;
    @(posedge mclk_i) disable iff (!rst_n_i)
      s_link_push |-> (mem_wdata_o == frame_r);
  endproperty
  a_link_data: assert property (p_link_data) else $error("link push data wrong");

  property p_save_first;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r == NSF_SAVE && mem_req_o && mem_ack_i) |-> (mem_wdata_o == fbp_r);
  endproperty
  a_save_first: assert property (p_save_first) else $error("first push not base");

  property p_push_addr;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (mem_req_o && mem_we_o && mem_ack_i) |-> (mem_addr_o == stp_r - NSF_SLOT_BYTES);
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("push address wrong");

  property p_done_fbp;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r == NSF_DONE) |=> (frame_base_pointer_o == $past(frame_r)) && done_o;
  endproperty
  a_done_fbp: assert property (p_done_fbp) else $error("base not frame");

  property p_reserve;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r == NSF_DONE) |=> (stack_top_pointer_o == $past(stp_r) - $past(store_r));
  endproperty
  a_reserve: assert property (p_reserve) else $error("storage not reserved");

  property p_lvl0;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r == NSF_SAVE && lvl_r == NSF_LVL_ZERO) |-> (st_nxt == NSF_SAVE || st_nxt == NSF_DONE);
  endproperty
  a_lvl0: assert property (p_lvl0) else $error("depth zero copied");

  property p_lvl1;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r == NSF_SAVE && lvl_r == NSF_LVL_ONE) |-> (st_nxt != NSF_RD);
  endproperty
  a_lvl1: assert property (p_lvl1) else $error("depth one copied");

  property p_rd_step;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r == NSF_RD && mem_req_o && mem_ack_i) |=> (fbp_r == $past(fbp_r) - NSF_SLOT_BYTES);
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("base step wrong");

  property p_seg;
    @(posedge mclk_i) disable iff (!rst_n_i)
      base_is_fbp_i |=> (seg_sel_o == NSF_SEG_STACK);
  endproperty
  a_seg: assert property (p_seg) else $error("segment not stack");

  sequence s_read_issue;
    mem_req_o && mem_ack_i && (st_r == NSF_RD);
  endsequence

  property p_rd_addr;
    @(posedge mclk_i) disable iff (!rst_n_i)
      s_read_issue |-> (!mem_we_o && mem_addr_o == fbp_r - NSF_SLOT_BYTES);
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("copy read address wrong");

  property p_copy_count;
    @(posedge mclk_i) disable iff (!rst_n_i)
      s_link_push |-> (chk_copies_r == lvl_r - NSF_LVL_ONE);
  endproperty
  a_copy_count: assert property (p_copy_count) else $error("display length wrong");

  property p_lvl_mod;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r == NSF_IDLE && start_i) |=> ({3'h0, lvl_r} == ($past(level_i) & 8'h1F));
  endproperty
  a_lvl_mod: assert property (p_lvl_mod) else $error("depth not taken modulo");

  property p_busy_ignore;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (st_r != NSF_IDLE && start_i) |=> ($stable(store_r) && $stable(lvl_r));
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("start taken while busy");
endmodule

// ### nsf_stack_mem.sv
// Behavioural stack memory on the far side of the frame builder.
// Assumes requests hold until ack; one 32-bit word per access.
`timescale 1ns/1ps
module nsf_stack_mem
  import nsf_pkg::*;
(
  // Clock and pacing
  input wire logic mclk_i,
  input wire logic slow_i,
  // Memory path
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [NSF_DW-1:0] addr_i,
  input wire logic [NSF_DW-1:0] wdata_i,
  output logic ack_o,
  output logic [NSF_DW-1:0] rdata_o,
  output logic rvalid_o
);
  // ----------------------------------------
  // Storage, write log and handshake
  // ----------------------------------------
  logic [NSF_DW-1:0] mem [logic [NSF_DW-1:0]];
  logic [NSF_DW-1:0] wa_q[$];
  logic [NSF_DW-1:0] wd_q[$];
  logic [NSF_DW-1:0] rd_addr = 32'h0;
  int wait_cnt = 0;
  int rd_cnt = -1;
  initial ack_o = 1'b0;
  initial rvalid_o = 1'b0;
  initial rdata_o = 32'h0;
  // Outside a valid beat the data line toggles so stale data never looks right.
  always @(posedge mclk_i) begin
    ack_o <= 1'b0;
    rvalid_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && ack_o) begin
      wait_cnt <= 0;
      if (we_i) begin
        mem[addr_i] = wdata_i;
        wa_q.push_back(addr_i);
        wd_q.push_back(wdata_i);
      end else begin
        rd_addr <= addr_i;
        rd_cnt <= slow_i ? 3 : 0;
      end
    end else if (req_i) begin
      if (wait_cnt >= (slow_i ? 3 : 0)) ack_o <= 1'b1;
      else wait_cnt <= wait_cnt + 1;
    end
    if (rd_cnt == 0) begin
      rvalid_o <= 1'b1;
      rdata_o <= mem.exists(rd_addr) ? mem[rd_addr] : {rd_addr[15:0], 16'hC0DE};
    end
    if (rd_cnt >= 0) rd_cnt <= rd_cnt - 1;
  end
endmodule

// ### test_nsf_builder.sv
// Self-checking testbench for the nested stack frame builder.
// Assumes nsf_stack_mem answers the memory path.
`timescale 1ns/1ps
module test_nsf_builder
  import nsf_pkg::*;
;
  typedef struct {
    logic [31:0] sto;
    logic [7:0] lvl;
    logic [31:0] fbp;
    logic [31:0] stp;
    logic slow;
    int n;
  } nsf_row_type;
  logic mclk_i = 0, rst_n_i = 0, start_i = 0, base_is_fbp_i = 0, slow = 0;
  logic [31:0] storage_i = 0, fbp_in_i = 0, stp_in_i = 0;
  logic [7:0] level_i = 0;
  logic busy_o, done_o, seg_sel_o, mem_req_o, mem_we_o, mem_ack_i, mem_rvalid_i;
  logic [31:0] frame_base_pointer_o, stack_top_pointer_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
  int num_errors = 0;
  int cmp_count = 0;
  nsf_row_type rows[7] = '{
    '{32'h800, 8'h00, 32'h9000, 32'h8000, 1'b0, 1},
    '{32'h0, 8'h01, 32'h9100, 32'h8100, 1'b1, 2},
    '{32'h10, 8'h02, 32'h9200, 32'h8200, 1'b0, 3},
    '{32'h800, 8'h03, 32'h9300, 32'h8300, 1'b1, 4},
    '{32'hC, 8'h1F, 32'h9400, 32'h8400, 1'b0, 32},
    '{32'h4, 8'h21, 32'h9500, 32'h8500, 1'b0, 2},
    '{32'hFFFF_FFFC, 8'h20, 32'h20, 32'h10, 1'b1, 1}};
  nsf_builder DUT (.mclk_i, .rst_n_i, .start_i, .storage_i, .level_i, .fbp_in_i, .stp_in_i,
    .base_is_fbp_i, .busy_o, .done_o, .frame_base_pointer_o, .stack_top_pointer_o, .seg_sel_o,
    .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i, .mem_rvalid_i);
  nsf_stack_mem MEM (.mclk_i(mclk_i), .slow_i(slow), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i),
    .rvalid_o(mem_rvalid_i));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wait_done;
    for (int i = 0; i < 3000; i++) begin
      @(negedge mclk_i);
      if (done_o === 1'b1) return;
    end
    num_errors++;
    results();
  endtask
  task automatic run(input nsf_row_type r, input bit poke);
    logic [31:0] sp, b;
    logic [31:0] ea[$];
    logic [31:0] ed[$];
    MEM.wa_q.delete();
    MEM.wd_q.delete();
    @(posedge mclk_i);
    slow <= r.slow;
    start_i <= 1'b1;
    storage_i <= r.sto;
    level_i <= r.lvl;
    fbp_in_i <= r.fbp;
    stp_in_i <= r.stp;
    @(posedge mclk_i);
    start_i <= 1'b0;
    if (poke) begin
      repeat (2) @(posedge mclk_i);
      start_i <= 1'b1;
      level_i <= 8'h00;
      stp_in_i <= 32'h0;
      @(posedge mclk_i);
      start_i <= 1'b0;
    end
    wait_done();
    sp = r.stp - 4;
    ea.push_back(sp);
    ed.push_back(r.fbp);
    b = r.fbp;
    for (int k = 1; k < r.lvl[4:0]; k++) begin
      b -= 4;
      sp -= 4;
      ea.push_back(sp);
      ed.push_back({b[15:0], 16'hC0DE});
    end
    if (r.lvl[4:0] != 0) begin
      sp -= 4;
      ea.push_back(sp);
      ed.push_back(r.stp - 4);
    end
    check(MEM.wa_q.size(), r.n);
    for (int k = 0; k < ea.size() && k < MEM.wa_q.size(); k++) begin
      check(MEM.wa_q[k], ea[k]);
      check(MEM.wd_q[k], ed[k]);
    end
    check(frame_base_pointer_o, r.stp - 4);
    check(stack_top_pointer_o, sp - r.sto);
  endtask
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (8) @(negedge mclk_i);
    check({29'h0, busy_o, done_o, mem_req_o}, 32'h0);
    check(frame_base_pointer_o, NSF_PTR_RESET);
    check(stack_top_pointer_o, NSF_PTR_RESET);
    @(posedge mclk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) run(rows[i], 1'b0);
    // A start while busy must leave the first entry untouched.
    run('{32'h20, 8'h03, 32'h9600, 32'h8600, 1'b1, 4}, 1'b1);
    check(busy_o, 1'b0);
    @(posedge mclk_i);
    base_is_fbp_i <= 1'b1;
    @(posedge mclk_i);
    base_is_fbp_i <= 1'b0;
    @(negedge mclk_i);
    check(seg_sel_o, NSF_SEG_STACK);
    @(negedge mclk_i);
    check(seg_sel_o, NSF_SEG_DATA);
    // Reset in mid-entry, then a clean entry must still complete.
    @(posedge mclk_i);
    start_i <= 1'b1;
    level_i <= 8'h03;
    @(posedge mclk_i);
    start_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b0;
    @(negedge mclk_i);
    check({30'h0, busy_o, mem_req_o}, 32'h0);
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    run(rows[2], 1'b0);
    results();
  end
endmodule
